/* File: core/sas_sequencer.sv */
`timescale 1ns/10ps
// SDRAM access sequencer of the external memory port
module sas_sequencer #(
  parameter sas_pkg::sas_var_t VARIANT = sas_pkg::VAR_B1,
  parameter int REGIONS = 4,
  parameter int ROW_W   = 12,
  parameter int COL_W   = 9,
  parameter int BANK_W  = 2,
  parameter int DW      = 32,
  parameter int RG_W    = (REGIONS > 1) ? $clog2(REGIONS) : 1
) (
  // Clock and reset
  input  wire logic               clock,
  input  wire logic               arst_n,
  // Access requests
  input  wire logic               req_valid,
  output logic                    req_ready,
  input  wire logic               req_write,
  input  wire logic [RG_W-1:0]    req_region,
  input  wire logic [BANK_W-1:0]  req_bank,
  input  wire logic [ROW_W-1:0]   req_row,
  input  wire logic [COL_W-1:0]   req_col,
  input  wire logic [2:0]         req_words,
  input  wire logic [3:0]         req_be_n,
  // Write and read data
  input  wire logic [DW-1:0]      wdata,
  output logic                    wdata_take,
  output logic                    rd_valid,
  output logic [DW-1:0]           rd_data,
  // Control and status
  input  wire logic [REGIONS-1:0] sdram_region_en,
  input  wire logic               cas_lat3,
  input  wire logic               init_set,
  output logic                    init_busy,
  input  wire logic               refresh_pending,
  output logic                    refresh_done,
  input  wire logic               page_expire,
  // Timing counts, each giving value plus one cycles
  input  wire logic [3:0]         close_to_open_count,
  input  wire logic [3:0]         refresh_to_any_count,
  input  wire logic [3:0]         row_to_col_count,
  input  wire logic [3:0]         hiz_after_precharge_count,
  input  wire logic [3:0]         read_to_close_count,
  input  wire logic [3:0]         write_recovery_count,
  input  wire logic [3:0]         write_to_close_count,
  input  wire logic [3:0]         write_to_read_count,
  // SDRAM pins
  output logic [REGIONS-1:0]      ext_cs_n,
  output logic                    ext_ras_n,
  output logic                    ext_cas_n,
  output logic                    ext_we_n,
  output logic [13:0]             ext_addr,
  output logic                    alt_precharge_pin,
  output logic [3:0]              byte_enable_n,
  output logic [DW-1:0]           dq_out,
  output logic                    dq_oe,
  input  wire logic [DW-1:0]      dq_in
);
  // ****************************************
  // Build checks and variant flags
  // ****************************************
  if (ROW_W > 12 || COL_W > 10 || COL_W < 3 || BANK_W > 2 ||
      REGIONS < 1 || DW < 1) begin : g_bad_param
    $error("sas_sequencer: unsupported parameter values");
  end

  localparam bit B1    = (VARIANT == sas_pkg::VAR_B1);
  localparam bit EARLY = (VARIANT == sas_pkg::VAR_B4E);

  // ****************************************
  // State
  // ****************************************
  sas_pkg::sas_state_t state_reg, state_next;
  logic                 init_reg, init_next;
  logic [3:0]           rcnt_reg, rcnt_next;
  logic                 pend_reg, pend_next;
  logic [2:0]           beat_reg, beat_next;
  logic                 a_wr_reg, a_wr_next;
  logic [RG_W-1:0]      a_rg_reg, a_rg_next;
  logic [BANK_W-1:0]    a_bk_reg, a_bk_next;
  logic [ROW_W-1:0]     a_row_reg, a_row_next;
  logic [COL_W-1:0]     a_col_reg, a_col_next;
  logic [2:0]           a_nw_reg, a_nw_next;
  logic [3:0]           a_be_reg, a_be_next;
  logic                 pg_open_reg, pg_open_next;
  logic [RG_W-1:0]      pg_rg_reg, pg_rg_next;
  logic [BANK_W-1:0]    pg_bk_reg, pg_bk_next;
  logic [ROW_W-1:0]     pg_row_reg, pg_row_next;
  logic [REGIONS-1:0]   cs_n_reg, cs_n_next;
  logic [2:0]           cmd_reg, cmd_next;
  logic [13:0]          addr_reg, addr_next;
  logic [3:0]           be_n_reg, be_n_next;
  logic [DW-1:0]        dq_reg, dq_next;
  logic                 oe_reg, oe_next;
  logic [2:0]           rdw_reg, rdw_next;
  logic                 rfd_reg, rfd_next;
  logic                 tl;
  logic [4:0]           tv;
  logic                 wb_en;
  logic [2:0]           wb_idx;

  sas_int_if it ();

  // ****************************************
  // Latency and gap figures
  // ****************************************
  logic [2:0]   cl;
  logic [4:0]   rd_sum, rd_sub, rd_hz, gap_b4r, w_rec, w_mid, gap_b4w;
  logic         hit;
  logic [REGIONS-1:0] a_sel;

  // Latency fixed at three for burst-1, else programmed
  assign cl = B1 ? sas_pkg::B1_CAS_LAT :
              (cas_lat3 ? sas_pkg::B1_CAS_LAT : sas_pkg::CL_TWO);
  // Close after read: data may run through the close
  assign rd_sum  = {2'h0, cl} + {2'h0, a_nw_reg};
  assign rd_sub  = {1'h0, hiz_after_precharge_count} + 5'h02;
  assign rd_hz   = (rd_sum > rd_sub) ? rd_sum - rd_sub : 5'h00;
  assign gap_b4r = (rd_hz > {1'h0, read_to_close_count}) ?
                   rd_hz : {1'h0, read_to_close_count};
  // Write recovery counts from the last data beat
  assign w_rec   = {1'h0, write_recovery_count} +
                   (EARLY ? sas_pkg::WR_LAST_EARLY :
                            sas_pkg::WR_LAST_NORMAL);
  assign w_mid   = (write_to_close_count > write_to_read_count) ?
                   {1'h0, write_to_close_count} :
                   {1'h0, write_to_read_count};
  assign gap_b4w = (w_rec > w_mid) ? w_rec : w_mid;
  // Open page match and chip select of the access
  assign hit   = pg_open_reg && pg_rg_reg == a_rg_reg &&
                 pg_bk_reg == a_bk_reg && pg_row_reg == a_row_reg;
  assign a_sel = {{(REGIONS-1){1'b0}}, 1'b1} << a_rg_reg;

  // ****************************************
  // Sequencer next state
  // ****************************************
  always_comb begin
    state_next = state_reg;
    init_next  = init_reg;
    rcnt_next  = rcnt_reg;
    pend_next  = pend_reg;
    beat_next  = beat_reg;
    a_wr_next  = a_wr_reg;
    a_rg_next  = a_rg_reg;
    a_bk_next  = a_bk_reg;
    a_row_next = a_row_reg;
    a_col_next = a_col_reg;
    a_nw_next  = a_nw_reg;
    a_be_next  = a_be_reg;
    pg_open_next = pg_open_reg;
    pg_rg_next   = pg_rg_reg;
    pg_bk_next   = pg_bk_reg;
    pg_row_next  = pg_row_reg;
    cs_n_next  = '1;
    cmd_next   = sas_pkg::CMD_NOP;
    addr_next  = addr_reg;
    be_n_next  = init_reg ? 4'hF : 4'h0;
    dq_next    = dq_reg;
    oe_next    = 1'b0;
    rdw_next   = rdw_reg;
    rfd_next   = 1'b0;
    req_ready  = 1'b0;
    wdata_take = 1'b0;
    tl         = 1'b0;
    tv         = 5'h00;
    wb_en      = 1'b0;
    wb_idx     = beat_reg;
    // Remaining beats of a burst-4 write stream
    if (!B1 && beat_reg != 3'h0) begin
      wb_en     = 1'b1;
      beat_next = (beat_reg == 3'h3) ? 3'h0 : beat_reg + 3'h1;
    end
    case (state_reg)
      sas_pkg::ST_IDLE: begin
        if (init_reg || refresh_pending) begin
          state_next = sas_pkg::ST_CLSA;
        end else if (pg_open_reg && page_expire) begin
          state_next = B1 ? sas_pkg::ST_CLSA : sas_pkg::ST_PRE1;
        end else if (req_valid && beat_reg == 3'h0) begin // Beats done
          req_ready  = 1'b1;
          a_wr_next  = req_write;
          a_rg_next  = req_region;
          a_bk_next  = req_bank;
          a_row_next = req_row;
          a_col_next = req_col;
          a_nw_next  = (req_words == 3'h0) ? 3'h1 : req_words;
          a_be_next  = req_be_n;
          pend_next  = 1'b1;
          state_next = sas_pkg::ST_ROUTE;
        end
      end
      sas_pkg::ST_ROUTE: begin
        if (hit) begin
          state_next = sas_pkg::ST_COL;
        end else if (!pg_open_reg) begin
          state_next = sas_pkg::ST_ACT;
        end else if (B1) begin
          state_next = sas_pkg::ST_CLSA;
        end else begin
          state_next = sas_pkg::ST_PRE1;
        end
      end
      sas_pkg::ST_CLSA: begin
        if (it.tm_done) begin
          cmd_next  = sas_pkg::CMD_PRE;
          cs_n_next = ~sdram_region_en;
          addr_next[sas_pkg::A_PRE_BIT] = 1'b1;
          pg_open_next = 1'b0;
          rcnt_next = 4'h0;
          tl = 1'b1;
          tv = {1'h0, close_to_open_count};
          if (init_reg || refresh_pending) begin
            state_next = sas_pkg::ST_AREF;
          end else if (pend_reg) begin
            state_next = sas_pkg::ST_ACT;
          end else begin
            state_next = sas_pkg::ST_IDLE;
          end
        end
      end
      sas_pkg::ST_AREF: begin
        if (it.tm_done) begin
          cmd_next  = sas_pkg::CMD_REF;
          cs_n_next = ~sdram_region_en;
          tl = 1'b1;
          tv = {1'h0, refresh_to_any_count};
          rcnt_next = rcnt_reg + 4'h1;
          if (init_reg) begin
            if (rcnt_next == sas_pkg::INIT_REFRESHES) begin
              state_next = sas_pkg::ST_MRS;
            end
          end else begin
            rfd_next   = 1'b1;
            state_next = pend_reg ? sas_pkg::ST_ACT : sas_pkg::ST_IDLE;
          end
        end
      end
      sas_pkg::ST_MRS: begin
        if (it.tm_done) begin
          cmd_next  = sas_pkg::CMD_MRS;
          cs_n_next = ~sdram_region_en;
          addr_next = B1 ? sas_pkg::MODE_B1 :
                      (cas_lat3 ? sas_pkg::MODE_CL3 :
                                  sas_pkg::MODE_CL2);
          init_next = 1'b0;
          tl = 1'b1;
          tv = {1'h0, close_to_open_count};
          state_next = sas_pkg::ST_IDLE;
        end
      end
      sas_pkg::ST_PRE1: begin
        if (it.tm_done) begin
          cmd_next  = sas_pkg::CMD_PRE;
          cs_n_next = ~({{(REGIONS-1){1'b0}}, 1'b1} << pg_rg_reg);
          addr_next[sas_pkg::A_PRE_BIT] = 1'b0;
          addr_next[sas_pkg::A_BANK_LSB +: BANK_W] = pg_bk_reg;
          pg_open_next = 1'b0;
          tl = 1'b1;
          tv = {1'h0, close_to_open_count};
          state_next = pend_reg ? sas_pkg::ST_ACT : sas_pkg::ST_IDLE;
        end
      end
      sas_pkg::ST_ACT: begin
        if (it.tm_done) begin
          cmd_next  = sas_pkg::CMD_ACT;
          cs_n_next = ~a_sel;
          addr_next = '0;
          addr_next[ROW_W-1:0] = a_row_reg;
          addr_next[sas_pkg::A_BANK_LSB +: BANK_W] = a_bk_reg;
          pg_open_next = 1'b1;
          pg_rg_next   = a_rg_reg;
          pg_bk_next   = a_bk_reg;
          pg_row_next  = a_row_reg;
          beat_next = 3'h0;
          tl = 1'b1;
          tv = {1'h0, row_to_col_count};
          state_next = sas_pkg::ST_COL;
        end
      end
      sas_pkg::ST_COL: begin
        if (it.tm_done) begin
          cs_n_next = ~a_sel;
          addr_next = '0;
          addr_next[sas_pkg::A_BANK_LSB +: BANK_W] = a_bk_reg;
          if (B1) begin
            // One command per word, write data with its column
            cmd_next = a_wr_reg ? sas_pkg::CMD_WR : sas_pkg::CMD_RD;
            addr_next[COL_W-1:0] = a_col_reg + COL_W'(beat_reg);
            wb_en    = a_wr_reg;
            rdw_next = 3'h1;
            beat_next = beat_reg + 3'h1;
            if (beat_reg == a_nw_reg - 3'h1) begin
              beat_next  = 3'h0;
              pend_next  = 1'b0;
              tl = 1'b1;
              tv = B1 ? {2'h0, sas_pkg::B1_CAS_LAT} -
                        sas_pkg::READ_OVERLAP_CYCLES : 5'h01;
              state_next = sas_pkg::ST_IDLE;
            end
          end else begin
            addr_next[COL_W-1:0] = a_col_reg;
            if (a_wr_reg && beat_reg == 3'h0) begin
              wb_en     = 1'b1;
              beat_next = 3'h1;
            end
            if (!a_wr_reg || !EARLY || beat_reg != 3'h0) begin
              cmd_next = a_wr_reg ? sas_pkg::CMD_WR : sas_pkg::CMD_RD;
              rdw_next = a_nw_reg;
              pend_next  = 1'b0;
              tl = 1'b1;
              tv = a_wr_reg ? gap_b4w : gap_b4r;
              state_next = sas_pkg::ST_IDLE;
            end else begin
              cs_n_next = '1;
            end
          end
        end
      end
      default: begin
        state_next = sas_pkg::ST_IDLE;
      end
    endcase
    // Drive one write beat, masking words beyond the request
    if (wb_en) begin
      oe_next = 1'b1;
      if (wb_idx < a_nw_reg) begin
        dq_next    = wdata;
        be_n_next  = a_be_reg;
        wdata_take = 1'b1;
      end else begin
        be_n_next = 4'hF;
      end
    end
    // A software request wins over the self-clear
    if (init_set) begin
      init_next = 1'b1;
      be_n_next = 4'hF;
    end
  end

  // Sequencer registers
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      state_reg   <= sas_pkg::ST_IDLE;
      init_reg    <= sas_pkg::INIT_RST;
      rcnt_reg    <= 4'h0;
      pend_reg    <= 1'b0;
      beat_reg    <= 3'h0;
      a_wr_reg    <= 1'b0;
      a_rg_reg    <= '0;
      a_bk_reg    <= '0;
      a_row_reg   <= '0;
      a_col_reg   <= '0;
      a_nw_reg    <= 3'h1;
      a_be_reg    <= 4'hF;
      pg_open_reg <= 1'b0;
      pg_rg_reg   <= '0;
      pg_bk_reg   <= '0;
      pg_row_reg  <= '0;
      cs_n_reg    <= '1;
      cmd_reg     <= sas_pkg::CMD_NOP;
      addr_reg    <= 14'h0000;
      be_n_reg    <= 4'hF;
      dq_reg      <= '0;
      oe_reg      <= 1'b0;
      rdw_reg     <= 3'h1;
      rfd_reg     <= 1'b0;
    end else begin
      state_reg   <= state_next;
      init_reg    <= init_next;
      rcnt_reg    <= rcnt_next;
      pend_reg    <= pend_next;
      beat_reg    <= beat_next;
      a_wr_reg    <= a_wr_next;
      a_rg_reg    <= a_rg_next;
      a_bk_reg    <= a_bk_next;
      a_row_reg   <= a_row_next;
      a_col_reg   <= a_col_next;
      a_nw_reg    <= a_nw_next;
      a_be_reg    <= a_be_next;
      pg_open_reg <= pg_open_next;
      pg_rg_reg   <= pg_rg_next;
      pg_bk_reg   <= pg_bk_next;
      pg_row_reg  <= pg_row_next;
      cs_n_reg    <= cs_n_next;
      cmd_reg     <= cmd_next;
      addr_reg    <= addr_next;
      be_n_reg    <= be_n_next;
      dq_reg      <= dq_next;
      oe_reg      <= oe_next;
      rdw_reg     <= rdw_next;
      rfd_reg     <= rfd_next;
    end
  end

  // ****************************************
  // Helpers and pins
  // ****************************************
  assign it.tm_load  = tl;
  assign it.tm_val   = tv;
  assign it.rd_issue = (cmd_reg == sas_pkg::CMD_RD) && (cs_n_reg != '1);
  assign it.rd_words = rdw_reg;
  assign it.rd_lat   = cl;

  sas_timer u_timer (
    .clock  (clock),
    .arst_n (arst_n),
    .t      (it)
  );

  sas_rd_capture #(.DW(DW)) u_capture (
    .clock    (clock),
    .arst_n   (arst_n),
    .c        (it),
    .dq_in    (dq_in),
    .rd_valid (rd_valid),
    .rd_data  (rd_data)
  );

  // Command pins, bit 10 leaves on its own pin
  assign ext_cs_n  = cs_n_reg;
  assign ext_ras_n = cmd_reg[2];
  assign ext_cas_n = cmd_reg[1];
  assign ext_we_n  = cmd_reg[0];
  assign ext_addr  = {addr_reg[13:11], 1'b0, addr_reg[9:0]};
  assign alt_precharge_pin = addr_reg[sas_pkg::A_PRE_BIT];
  assign byte_enable_n = be_n_reg;
  assign dq_out       = dq_reg;
  assign dq_oe        = oe_reg;
  assign init_busy    = init_reg;
  assign refresh_done = rfd_reg;
endmodule

/* File: common/sas_pkg.sv */
package sas_pkg;

  // ****************************************
  // Variants, commands and states
  // ****************************************
  typedef enum logic [1:0] {
    VAR_B1  = 2'h0,
    VAR_B4  = 2'h1,
    VAR_B4E = 2'h2
  } sas_var_t;

  typedef enum logic [3:0] {
    ST_IDLE  = 4'h0,
    ST_ROUTE = 4'h1,
    ST_CLSA  = 4'h2,
    ST_AREF  = 4'h3,
    ST_MRS   = 4'h4,
    ST_PRE1  = 4'h5,
    ST_ACT   = 4'h6,
    ST_COL   = 4'h7
  } sas_state_t;

  // Command codes as {ras_n, cas_n, we_n}
  localparam logic [2:0] CMD_NOP = 3'h7;
  localparam logic [2:0] CMD_ACT = 3'h3;
  localparam logic [2:0] CMD_RD  = 3'h5;
  localparam logic [2:0] CMD_WR  = 3'h4;
  localparam logic [2:0] CMD_MRS = 3'h0;
  localparam logic [2:0] CMD_PRE = 3'h2;
  localparam logic [2:0] CMD_REF = 3'h1;

  // ****************************************
  // Mode values, fields and timing
  // ****************************************
  localparam logic [13:0] MODE_B1  = 14'h0030;
  localparam logic [13:0] MODE_CL3 = 14'h0032;
  localparam logic [13:0] MODE_CL2 = 14'h0022;
  localparam int          A_PRE_BIT  = 10;
  localparam int          A_BANK_LSB = 12;
  localparam int          CNT_W      = 4;
  localparam int          TMR_W      = 5;
  localparam logic [2:0]  B1_CAS_LAT = 3'h3;
  localparam logic [2:0]  CL_TWO     = 3'h2;
  localparam logic [2:0]  B4_WORDS   = 3'h4;
  localparam logic [4:0]  READ_OVERLAP_CYCLES = 5'h02;
  localparam logic [3:0]  INIT_REFRESHES = 4'h8;
  localparam logic [4:0]  WR_LAST_NORMAL = 5'h03;
  localparam logic [4:0]  WR_LAST_EARLY  = 5'h02;
  localparam logic        INIT_RST = 1'b1;
endpackage

/* File: common/sas_int_if.sv */
`timescale 1ns/10ps
// Links the sequencer with its timer and read capture
interface sas_int_if;
  logic                         rd_issue;
  logic [2:0]                   rd_words;
  logic [2:0]                   rd_lat;
  logic                         tm_load;
  logic [sas_pkg::TMR_W-1:0]    tm_val;
  logic                         tm_done;

  modport seq (output rd_issue, rd_words, rd_lat, tm_load, tm_val,
               input  tm_done);
  modport cap (input rd_issue, rd_words, rd_lat);
  modport tmr (input tm_load, tm_val, output tm_done);
endinterface

/* File: core/sas_timer.sv */
`timescale 1ns/10ps
// Command spacing timer: done once the loaded count ran out
module sas_timer (
  // Clock and reset
  input wire logic clock,
  input wire logic arst_n,
  // Sequencer side
  sas_int_if.tmr   t
);
  logic [sas_pkg::TMR_W-1:0] cnt_reg;
  logic [sas_pkg::TMR_W-1:0] cnt_next;

  // Load or count down to zero
  always_comb begin
    cnt_next = cnt_reg;
    if (t.tm_load) begin
      cnt_next = t.tm_val;
    end else if (cnt_reg != '0) begin
      cnt_next = cnt_reg - 1'b1;
    end
  end

  // Count register
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      cnt_reg <= '0;
    end else begin
      cnt_reg <= cnt_next;
    end
  end

  assign t.tm_done = (cnt_reg == '0);
endmodule

/* File: core/sas_rd_capture.sv */
`timescale 1ns/10ps
// Read data capture at CAS latency, surplus burst words dropped
module sas_rd_capture #(
  parameter int DW = 32
) (
  // Clock and reset
  input  wire logic          clock,
  input  wire logic          arst_n,
  // Sequencer side
  sas_int_if.cap             c,
  // Memory data pins and user side
  input  wire logic [DW-1:0] dq_in,
  output logic               rd_valid,
  output logic [DW-1:0]      rd_data
);
  logic [DW-1:0] s1_reg;
  logic [DW-1:0] s2_reg;
  logic [DW-1:0] dat_reg;
  logic [DW-1:0] dat_next;
  logic          val_reg;
  logic [7:0]    pend_reg;
  logic [7:0]    pend_next;
  logic [7:0]    mask;

  // Mark the cycles in which wanted words leave the synchroniser
  always_comb begin
    case (c.rd_words)
      3'h1:    mask = 8'h01;
      3'h2:    mask = 8'h03;
      3'h3:    mask = 8'h07;
      default: mask = 8'h0F;
    endcase
    pend_next = pend_reg >> 1;
    if (c.rd_issue) begin
      pend_next = pend_next | (mask << (c.rd_lat + 3'h1));
    end
    dat_next = pend_reg[0] ? s2_reg : dat_reg;
  end

  // Pin synchroniser and capture register
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      s1_reg   <= '0;
      s2_reg   <= '0;
      dat_reg  <= '0;
      val_reg  <= 1'b0;
      pend_reg <= '0;
    end else begin
      s1_reg   <= dq_in;
      s2_reg   <= s1_reg;
      dat_reg  <= dat_next;
      val_reg  <= pend_reg[0];
      pend_reg <= pend_next;
    end
  end

  assign rd_valid = val_reg;
  assign rd_data  = dat_reg;
endmodule

/* File: bench/sas_seq_chk.sv */
`timescale 1ns/10ps
// Port checker of the sequencer
module sas_seq_chk #(
  parameter sas_pkg::sas_var_t VARIANT = sas_pkg::VAR_B1,
  parameter int                REGIONS = 4
) (
  // Clock, reset and status
  input wire logic               clock,
  input wire logic               arst_n,
  input wire logic               req_ready,
  input wire logic               cas_lat3,
  input wire logic               init_busy,
  input wire logic               refresh_done,
  input wire logic               rd_valid,
  // SDRAM pins
  input wire logic [REGIONS-1:0] ext_cs_n,
  input wire logic               ext_ras_n,
  input wire logic               ext_cas_n,
  input wire logic               ext_we_n,
  input wire logic [13:0]        ext_addr,
  input wire logic               alt_precharge_pin,
  input wire logic [3:0]         byte_enable_n,
  input wire logic               dq_oe
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!arst_n);
  logic [2:0] cmd;
  logic       sel;
  // Command decode
  assign cmd = sel ? {ext_ras_n, ext_cas_n, ext_we_n} : sas_pkg::CMD_NOP;
  assign sel = ~&ext_cs_n;
  a_mode_value:
    assert property (cmd == sas_pkg::CMD_MRS |-> ext_addr ==
      (VARIANT == sas_pkg::VAR_B1 ? sas_pkg::MODE_B1 :
       cas_lat3 ? sas_pkg::MODE_CL3 : sas_pkg::MODE_CL2)) else $error("mode");
  a_mode_in_init:
    assert property (cmd == sas_pkg::CMD_MRS |-> init_busy || $past(init_busy))
    else $error("mode load late");
  a_init_clears:
    assert property (cmd == sas_pkg::CMD_MRS |-> ##[0:2] !init_busy)
    else $error("init stuck");
  a_close_all:
    assert property (init_busy && cmd == sas_pkg::CMD_PRE |-> alt_precharge_pin)
    else $error("close-all line low");
  a_init_mask:
    assert property (init_busy |-> byte_enable_n == 4'hF) else $error("mask");
  a_init_hold:
    assert property (init_busy |-> !req_ready) else $error("ready in init");
  a_read_lat:
    assert property (cas_lat3 && cmd == sas_pkg::CMD_RD |-> ##6 rd_valid)
    else $error("read latency");
  a_write_data:
    assert property (cmd == sas_pkg::CMD_WR |-> dq_oe) else $error("wr data");
  a_ref_done:
    assert property (refresh_done |-> cmd == sas_pkg::CMD_REF)
    else $error("refresh done");
endmodule

/* File: bench/sas_sdram_model.sv */
`timescale 1ns/10ps
// SDRAM model: bursts of four, latency from the mode load
module sas_sdram_model (
  // Clock and pins
  input wire logic        clock,
  input wire logic [3:0]  ext_cs_n,
  input wire logic        ext_ras_n,
  input wire logic        ext_cas_n,
  input wire logic        ext_we_n,
  input wire logic [13:0] ext_addr,
  input wire logic [3:0]  byte_enable_n,
  input wire logic [31:0] dq_out,
  output logic     [31:0] dq_in = 32'h0
);
  logic [31:0] mem [int];
  logic [31:0] pipe [8];
  logic [11:0] row [16];
  logic [7:0]  pv = 8'h00;
  logic [2:0]  cmd;
  int          cl = 3, wb = 0, wk = 4, key, rg = 0, i;
  // Unwritten words read as a pattern of their address
  function automatic logic [31:0] word(input int k);
    return mem.exists(k) ? mem[k] : 32'h5A000000 ^ k;
  endfunction
  // Commands taken on each rising edge
  always @(posedge clock) begin
    cmd = &ext_cs_n ? sas_pkg::CMD_NOP : {ext_ras_n, ext_cas_n, ext_we_n};
    for (i = 0; i < 4; i++) if (!ext_cs_n[i]) rg = i;
    for (i = 0; i < 7; i++) pipe[i] = pipe[i + 1];
    pv = pv >> 1;
    key = rg * 4 + ext_addr[13:12];
    if (cmd == sas_pkg::CMD_ACT) row[key] = ext_addr[11:0];
    key = (key * 4096 + row[key]) * 512 + ext_addr[8:0];
    if (cmd == sas_pkg::CMD_MRS) cl = ext_addr[6:4];
    for (i = 0; i < 4 && cmd == sas_pkg::CMD_RD; i++) begin
      pipe[cl - 1 + i] = word(key + i);
      pv[cl - 1 + i] = 1'b1;
    end
    wk = cmd == sas_pkg::CMD_WR ? 0 : wk + 1;
    wb = cmd == sas_pkg::CMD_WR ? key : wb;
    for (i = 0; i < 4 && wk < 4; i++)
      if (!byte_enable_n[i]) mem[wb + wk] = word(wb + wk) &
        ~(32'hFF << 8 * i) | dq_out & 32'hFF << 8 * i;
    dq_in <= pv[0] ? pipe[0] : ~dq_in; // Released bus never holds
  end
endmodule

/* File: bench/sdram_access_sequencer_test.sv */
`timescale 1ns/10ps
// Bench of the burst-4 sequencer against a shadow memory
module sdram_access_sequencer_test;
  logic clock = 1'b0, arst_n = 1'b0, req_valid = 1'b0, req_write = 1'b0;
  logic cas_lat3 = 1'b1, init_set = 1'b0, page_expire = 1'b0;
  logic refresh_pending = 1'b0;
  logic [1:0]  req_region = 2'h0, req_bank = 2'h0;
  logic [11:0] req_row = 12'h000;
  logic [8:0]  req_col = 9'h000;
  logic [2:0]  req_words = 3'h1;
  logic [3:0]  req_be_n = 4'h0, sdram_region_en = 4'hF;
  logic [31:0] wdata = 32'h0, cnt = 32'h0, rd_data, dq_out, dq_in, wd;
  logic [13:0] ext_addr;
  logic [3:0]  ext_cs_n, byte_enable_n;
  logic req_ready, wdata_take, rd_valid, init_busy, refresh_done;
  logic ext_ras_n, ext_cas_n, ext_we_n, alt_precharge_pin, dq_oe;
  logic [31:0] shadow [int];
  logic [31:0] wq [$], eq [$];
  int fail_count = 0, checks_done = 0, seed = 70398, i, k, t, j, key;
  sas_sequencer #(.VARIANT(sas_pkg::VAR_B4)) u_dut (.*,
    .close_to_open_count(cnt[3:0]), .refresh_to_any_count(cnt[7:4]),
    .row_to_col_count(cnt[11:8]), .hiz_after_precharge_count(cnt[15:12]),
    .read_to_close_count(cnt[19:16]), .write_recovery_count(cnt[23:20]),
    .write_to_close_count(cnt[27:24]), .write_to_read_count(cnt[31:28]));
  sas_sdram_model u_mem (.*);
  initial forever #5 clock = ~clock;
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic bound(input int n);
    if (n >= 900) begin
      fail_count++;
      conclude();
    end
  endtask
  // One request; the shadow memory gives the expected words
  task automatic access(input bit wr);
    int n;
    n = 1 + $unsigned($random(seed)) % 4;
    @(negedge clock);
    {req_region, req_bank} = 4'($random(seed));
    req_row = 12'($unsigned($random(seed)) % 3);
    req_col = 9'($random(seed) & 12);
    req_be_n = wr ? 4'($random(seed)) : 4'h0;
    {req_words, req_write} = {n[2:0], wr};
    key = ((req_region * 4 + req_bank) * 4096 + req_row) * 512 + req_col;
    for (k = 0; k < n; k++) begin
      wd = $random(seed);
      if (!shadow.exists(key + k)) shadow[key + k] = 32'h5A000000 ^ (key + k);
      for (i = 0; i < 4; i++)
        if (wr && !req_be_n[i]) shadow[key + k][8*i +: 8] = wd[8*i +: 8];
      if (wr) wq.push_back(wd);
      else eq.push_back(shadow[key + k]);
    end
    req_valid = 1'b1;
    #1;
    for (t = 0; t < 900 && req_ready !== 1'b1; t++) begin
      @(negedge clock);
      #1;
    end
    bound(t);
    @(negedge clock);
    req_valid = 1'b0;
    for (t = 0; t < 900 && eq.size() + wq.size() > 0; t++) @(negedge clock);
    bound(t);
  endtask
  // Write words handed over; read words compared
  always @(posedge clock) if (wdata_take === 1'b1 && wq.size() > 0) wq.delete(0);
  always @(negedge clock) begin
    if (wq.size() > 0) wdata <= wq[0];
    if (rd_valid === 1'b1) begin
      if (eq.size() == 0) eq.push_back(~rd_data);
      check(rd_data, eq.pop_front());
    end
  end
  // Reset, init, random traffic, then a second init at latency two
  initial begin
    cnt = $random(seed) & 32'h33333333;
    repeat (20) @(posedge clock);
    check({init_busy, ext_cs_n}, 5'h1F);
    @(negedge clock);
    arst_n = 1'b1;
    for (j = 0; j < 2; j++) begin
      for (t = 0; t < 900 && init_busy !== 1'b0; t++) @(negedge clock);
      bound(t);
      repeat (40) begin
        access($random(seed) % 2 != 0);
        page_expire = $random(seed) % 4 == 0;
        refresh_pending = $random(seed) % 4 == 0;
        for (t = 0; t < 900 && refresh_pending && refresh_done !== 1'b1; t++)
          @(negedge clock);
        bound(t);
        refresh_pending = 1'b0;
      end
      $display("traffic pass %0d done", j);
      {page_expire, cas_lat3, init_set} = 3'h1;
      @(negedge clock);
      check(init_busy, 1'b1);
      init_set = 1'b0;
    end
    conclude();
  end
endmodule
bind sas_sequencer sas_seq_chk #(.VARIANT(VARIANT), .REGIONS(REGIONS))
  u_chk (.*);
